// [core/exc_consts.svh]
// Timing constants for the reset and interrupt input block
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH
`define CLK_PERIOD_NS 5
`define PWRUP_RESET_MS 1
`define PWRUP_RESET_CYC ((`PWRUP_RESET_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARM_RESET_CYC 15
`define SOFT_RESET_CYC 15
`define NMI_LOW_CYC 4
`define NMI_HIGH_CYC 4
`define SYSMGMT_BASE_REG_RESET 32'h00030000
`define SYNC_STAGES 3
`endif

// [core/exc_pkg.sv]
// Types for the reset and interrupt input block
package exc_pkg;
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_ACK = 4'b0010,
		ST_SMM = 4'b0100,
		ST_RST = 4'b1000
	} cpu_state_t;
	typedef logic [31:0] word_t;
endpackage : exc_pkg

// [core/exc_if.sv]
// Pins between board logic and the processor input block
`timescale 1ns/1ps
interface exc_if;
	logic hard_reset;
	logic soft_reset_in;
	logic maskable_irq_req;
	logic nmi_req;
	logic sysmgmt_req_n;
	logic sysmgmt_active_n;
	modport cpu (input hard_reset, input soft_reset_in, input maskable_irq_req,
		input nmi_req, input sysmgmt_req_n, output sysmgmt_active_n);
	modport board (output hard_reset, output soft_reset_in, output maskable_irq_req,
		output nmi_req, output sysmgmt_req_n, input sysmgmt_active_n);
endinterface : exc_if

// [core/exc_board.sv]
// Board end: reset generator, interrupt and power-management sources
`timescale 1ns/1ps
`include "exc_consts.svh"
module exc_board #(
	parameter int PWRUP_CYC = `PWRUP_RESET_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CE,
	// Requests from the user
	input wire logic HARD_RESET_REQ,
	input wire logic SOFT_RESET_REQ,
	input wire logic IRQ_SET,
	input wire logic IRQ_ACKED,
	input wire logic NMI_REQ,
	input wire logic SMI_REQ,
	// Status
	output logic SMM_SEEN,
	output logic BUSY,
	// Pins
	exc_if.board pins
);
	localparam int CW = $clog2(PWRUP_CYC + 1);
	logic [CW-1:0] hrst_cnt_r;
	logic [4:0] srst_cnt_r;
	logic [2:0] nmi_low_r;
	logic nmi_r;
	logic irq_r;
	logic smi_r;
	wire nmi_ok = (nmi_low_r >= 3'(`NMI_LOW_CYC));
	wire hrst_on = (hrst_cnt_r != '0);
	wire srst_on = (srst_cnt_r != '0);

	assign pins.hard_reset = hrst_on;
	assign pins.soft_reset_in = srst_on;
	assign pins.maskable_irq_req = irq_r;
	assign pins.nmi_req = nmi_r;
	assign pins.sysmgmt_req_n = ~smi_r;
	assign SMM_SEEN = ~pins.sysmgmt_active_n;
	assign BUSY = hrst_on | srst_on | irq_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			hrst_cnt_r <= CW'(PWRUP_CYC); // RL2
			srst_cnt_r <= '0;
			nmi_low_r <= '0;
			nmi_r <= 1'b0;
			irq_r <= 1'b0;
			smi_r <= 1'b0;
		end else if (CE) begin
			if (HARD_RESET_REQ)
				hrst_cnt_r <= CW'(`WARM_RESET_CYC); // RL3
			else if (hrst_on)
				hrst_cnt_r <= hrst_cnt_r - 1'b1;
			if (SOFT_RESET_REQ)
				srst_cnt_r <= 5'(`SOFT_RESET_CYC); // RL12
			else if (srst_on)
				srst_cnt_r <= srst_cnt_r - 1'b1;
			// Held until acknowledges done, the cpu only samples the level
			if (IRQ_SET)
				irq_r <= 1'b1;
			else if (IRQ_ACKED)
				irq_r <= 1'b0; // RL7
			// High for a few cycles, a one-cycle pulse dies in the cpu's filter
			if (nmi_r) begin
				if (nmi_low_r == 3'(`NMI_HIGH_CYC - 1)) begin
					nmi_r <= 1'b0;
					nmi_low_r <= '0;
				end else begin
					nmi_low_r <= nmi_low_r + 1'b1;
				end
			end else if (NMI_REQ && nmi_ok) begin
				nmi_r <= 1'b1; // RL10
				nmi_low_r <= '0;
			end else if (!nmi_ok) begin
				nmi_low_r <= nmi_low_r + 1'b1;
			end
			smi_r <= SMI_REQ;
		end
	end
endmodule : exc_board

// [core/exc_cpu.sv]
// Processor end: reset, interrupt and system-management input handling
// Operation
// (RL1) Held in reset, restart from known state
// (RL2) Power-up hard reset held 1 ms
// (RL3) Warm hard reset held 15 clocks
// (RL4) Hard reset high active, asynchronous
// (RL5) Maskable interrupt serviced only when enabled
// (RL6) Accepted interrupt gives two locked acknowledges
// (RL7) Source holds request through both acknowledges
// (RL8) Maskable request level sensitive, active high
// (RL9) Non-maskable interrupt on rising edge only
// (RL10) Non-maskable input low four clocks first
// (RL11) Soft reset like hard, base kept
// (RL12) Soft reset held 15 clocks
// (RL13) Falling request enters mode after instruction
// (RL14) Request tested at boundaries and iterations
// (RL15) Never splits locked cycles or nests mode
// (RL16) One further request latched until resume
// (RL17) Active output low from save through restore
// (RL18) Asynchronous inputs synchronised before decisions
`timescale 1ns/1ps
`include "exc_consts.svh"
module exc_cpu (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CE,
	// Execution core status
	input wire logic INSN_BOUNDARY,
	input wire logic STRING_ITER,
	input wire logic LOCKED_SEQ,
	input wire logic INT_ENABLE,
	input wire logic ACK_CYCLE_DONE,
	input wire logic SAVE_DONE,
	input wire logic RESUME_EXEC,
	input wire logic RESTORE_LAST,
	input wire logic BASE_WE,
	input wire logic [31:0] BASE_WDATA,
	// Execution core requests
	output logic CORE_RESET,
	output logic INTA_REQ,
	output logic INTA_LOCK,
	output logic NMI_TAKE,
	output logic SMM_ENTER,
	output logic [31:0] SYSMGMT_BASE,
	output logic SYSMGMT_MODE,
	// Pins
	exc_if.cpu pins
);
	localparam int N = `SYNC_STAGES;
	logic [N-1:0] hrst_s_r;
	logic [N-1:0] srst_s_r;
	logic [N-1:0] irq_s_r;
	logic [N-1:0] nmi_s_r;
	logic [N-1:0] smi_s_r;
	logic hrst_r;
	logic srst_r;
	logic irq_r;
	logic nmi_r;
	logic smi_n_r;
	logic smi_pend_r;
	logic smi_nest_r;
	logic [1:0] ack_cnt_r;
	logic nmi_evt_r;
	logic act_n_r;
	exc_pkg::cpu_state_t state_r;
	exc_pkg::cpu_state_t state_nxt;
	exc_pkg::word_t base_r;

	// Settled value: change counts once stages two and three agree
	function automatic logic settle(input logic [N-1:0] s, input logic cur);
		settle = (s[1] == s[2]) ? s[2] : cur;
	endfunction : settle

	wire hrst_nxt = settle(hrst_s_r, hrst_r);
	wire srst_nxt = settle(srst_s_r, srst_r);
	wire irq_nxt = settle(irq_s_r, irq_r);
	wire nmi_nxt = settle(nmi_s_r, nmi_r);
	wire smi_n_nxt = settle(smi_s_r, smi_n_r);
	wire smi_fall = smi_n_r & ~smi_n_nxt;
	wire nmi_rise = ~nmi_r & nmi_nxt; // RL9
	wire any_rst = hrst_r | srst_r;
	wire in_run = (state_r == exc_pkg::ST_RUN);
	wire in_ack = (state_r == exc_pkg::ST_ACK);
	wire in_smm = (state_r == exc_pkg::ST_SMM);
	wire ack_step = in_ack & ACK_CYCLE_DONE;
	wire smm_leave = in_smm & RESUME_EXEC;
	wire base_load = BASE_WE & in_smm;
	wire act_release = RESTORE_LAST & in_smm;
	wire take_point = (INSN_BOUNDARY | STRING_ITER) & ~LOCKED_SEQ; // RL14 RL15
	wire smi_go = in_run & smi_pend_r & take_point; // RL13
	wire irq_go = in_run & irq_r & INT_ENABLE
		& INSN_BOUNDARY & ~LOCKED_SEQ & ~smi_go; // RL5 RL8
	wire ack_last = ack_step & (ack_cnt_r == 2'h1);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			exc_pkg::ST_RST: if (!any_rst) state_nxt = exc_pkg::ST_RUN; // RL1
			exc_pkg::ST_RUN: begin
				if (smi_go)
					state_nxt = exc_pkg::ST_SMM;
				else if (irq_go)
					state_nxt = exc_pkg::ST_ACK;
			end
			exc_pkg::ST_ACK: if (ack_last) state_nxt = exc_pkg::ST_RUN; // RL6
			exc_pkg::ST_SMM: if (RESUME_EXEC) state_nxt = exc_pkg::ST_RUN;
			default: state_nxt = exc_pkg::ST_RST;
		endcase
		if (any_rst)
			state_nxt = exc_pkg::ST_RST; // RL4 RL11
	end

	// Synchronisers: only a reset constant on the async clear
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			hrst_s_r <= '0;
			srst_s_r <= '0;
			irq_s_r <= '0;
			nmi_s_r <= '0;
			smi_s_r <= '1;
			hrst_r <= 1'b0;
			srst_r <= 1'b0;
			irq_r <= 1'b0;
			nmi_r <= 1'b0;
			smi_n_r <= 1'b1;
		end else if (CE) begin
			hrst_s_r <= {hrst_s_r[N-2:0], pins.hard_reset}; // RL18
			srst_s_r <= {srst_s_r[N-2:0], pins.soft_reset_in};
			irq_s_r <= {irq_s_r[N-2:0], pins.maskable_irq_req};
			nmi_s_r <= {nmi_s_r[N-2:0], pins.nmi_req};
			smi_s_r <= {smi_s_r[N-2:0], pins.sysmgmt_req_n};
			hrst_r <= hrst_nxt;
			srst_r <= srst_nxt;
			irq_r <= irq_nxt;
			nmi_r <= nmi_nxt;
			smi_n_r <= smi_n_nxt;
		end
	end

	// State and acknowledge count
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_r <= exc_pkg::ST_RST;
			ack_cnt_r <= 2'h0;
		end else if (CE) begin
			state_r <= state_nxt;
			if (irq_go)
				ack_cnt_r <= 2'h0;
			else if (ack_step)
				ack_cnt_r <= ack_cnt_r + 2'h1; // RL6
		end
	end

	// Edge seen during reset is dropped, not held over
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			nmi_evt_r <= 1'b0;
		else if (CE)
			nmi_evt_r <= nmi_rise & ~any_rst; // RL9
	end

	// Only a hard reset restores the base
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			base_r <= `SYSMGMT_BASE_REG_RESET;
		end else if (CE) begin
			if (hrst_r)
				base_r <= `SYSMGMT_BASE_REG_RESET; // RL11
			else if (base_load)
				base_r <= BASE_WDATA;
		end
	end

	// Pending and nested requests, a new fall beats every clear except reset
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			smi_pend_r <= 1'b0;
			smi_nest_r <= 1'b0;
		end else if (CE) begin
			if (any_rst) begin
				smi_pend_r <= 1'b0;
				smi_nest_r <= 1'b0;
			end else if (smm_leave) begin
				smi_pend_r <= smi_nest_r | smi_fall; // RL16
				smi_nest_r <= 1'b0;
			end else if (in_smm) begin
				if (smi_fall)
					smi_nest_r <= 1'b1; // RL15 RL16
			end else if (smi_go) begin
				smi_pend_r <= smi_fall;
			end else if (smi_fall) begin
				smi_pend_r <= 1'b1;
			end
		end
	end

	// Active output, low from entry until the last restore
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			act_n_r <= 1'b1;
		end else if (CE) begin
			if (any_rst)
				act_n_r <= 1'b1;
			else if (smi_go)
				act_n_r <= 1'b0; // RL17
			else if (act_release)
				act_n_r <= 1'b1; // RL17
		end
	end

	assign CORE_RESET = (state_r == exc_pkg::ST_RST); // RL1
	assign INTA_REQ = (state_r == exc_pkg::ST_ACK) & ~ACK_CYCLE_DONE | ack_last;
	// Lock stays up through the last acknowledge cycle itself
	assign INTA_LOCK = in_ack; // RL6
	assign NMI_TAKE = nmi_evt_r;
	assign SMM_ENTER = smi_go & ~SAVE_DONE;
	assign SYSMGMT_BASE = base_r;
	assign SYSMGMT_MODE = (state_r == exc_pkg::ST_SMM);
	assign pins.sysmgmt_active_n = act_n_r;
endmodule : exc_cpu

// [tb/exc_monitor.sv]
// Checker on the pins and core status of the processor end
`timescale 1ns/1ps
module exc_monitor (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Pins
	input wire logic hard_reset,
	input wire logic soft_reset_in,
	input wire logic nmi_req,
	input wire logic sysmgmt_active_n,
	// Core status
	input wire logic CORE_RESET,
	input wire logic NMI_TAKE,
	input wire logic SMM_ENTER,
	input wire logic SYSMGMT_MODE,
	input wire logic INTA_REQ,
	input wire logic INTA_LOCK,
	input wire logic INT_ENABLE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Sync chain sets the bound
	property p_rst; hard_reset |-> ##[0:5] CORE_RESET; endproperty
	a_rst: assert property (p_rst) else $error("reset missed");
	property p_srst; $rose(soft_reset_in) |-> ##[1:6] CORE_RESET; endproperty
	a_srst: assert property (p_srst) else $error("soft reset missed");
	property p_nmi; $rose(nmi_req) && !CORE_RESET |-> ##[2:6] NMI_TAKE; endproperty
	a_nmi: assert property (p_nmi) else $error("edge not taken");
	property p_nlow; $rose(nmi_req) |-> !$past(nmi_req, 4); endproperty
	a_nlow: assert property (p_nlow) else $error("low too short");
	property p_act; $fell(sysmgmt_active_n) |-> SYSMGMT_MODE; endproperty
	a_act: assert property (p_act) else $error("active outside mode");
	property p_ent; SMM_ENTER |=> SYSMGMT_MODE && !sysmgmt_active_n; endproperty
	a_ent: assert property (p_ent) else $error("entry lost");
	property p_lock; INTA_REQ |-> INTA_LOCK; endproperty
	a_lock: assert property (p_lock) else $error("ack unlocked");
	property p_ien; $rose(INTA_LOCK) |-> $past(INT_ENABLE); endproperty
	a_ien: assert property (p_ien) else $error("masked irq taken");
	c_smm: cover property (SMM_ENTER);
	c_nmi: cover property (NMI_TAKE);
	c_ack: cover property ($rose(INTA_REQ));
endmodule : exc_monitor

// [tb/tb_cpu_reset_interrupt_sysmgmt_inputs.sv]
// Bench joining board end and processor end
`timescale 1ns/1ps
module tb_cpu_reset_interrupt_sysmgmt_inputs;
	logic SYS_CLK = 0, RST = 1, CE = 1, HARD_RESET_REQ = 0, SOFT_RESET_REQ = 0;
	logic IRQ_SET = 0, IRQ_ACKED = 0, NMI_REQ = 0, SMI_REQ = 0, INSN_BOUNDARY = 0;
	logic STRING_ITER = 0, LOCKED_SEQ = 0, INT_ENABLE = 0, ACK_CYCLE_DONE = 0;
	logic SAVE_DONE = 0, RESUME_EXEC = 0, RESTORE_LAST = 0, BASE_WE = 0;
	logic SMM_SEEN, BUSY, CORE_RESET, INTA_REQ, INTA_LOCK, NMI_TAKE, SMM_ENTER, SYSMGMT_MODE;
	logic [31:0] BASE_WDATA = 32'h0, SYSMGMT_BASE;
	int errors = 0, samples_checked = 0;
	exc_if bus ();
	// Short power-up hold keeps the run brief
	exc_board #(.PWRUP_CYC(20)) u_exc_board (.pins(bus.board), .*);
	exc_cpu u_exc_cpu (.pins(bus.cpu), .*);
	exc_monitor u_exc_monitor (.hard_reset(bus.hard_reset), .soft_reset_in(bus.soft_reset_in),
		.nmi_req(bus.nmi_req), .sysmgmt_active_n(bus.sysmgmt_active_n), .*);
	always #2.5 SYS_CLK = ~SYS_CLK;
	task cy(int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : cy
	task chk(logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	// Trailing idle cycle avoids two writes in one step
	task automatic pl(ref logic s);
		s = 1;
		cy(1);
		s = 0;
		cy(1);
	endtask : pl
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 60 && s !== v; i++) cy(1);
	endtask : wt
	task final_report;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		#20000;
		errors++;
		final_report;
	end
	initial begin
		cy(4);
		RST = 0;
		wt(CORE_RESET, 0);
		chk(CORE_RESET, 0);
		chk(SYSMGMT_BASE, 32'h00030000);
		chk(bus.sysmgmt_active_n, 1);
		$display("reset done");
		INSN_BOUNDARY = 1;
		pl(IRQ_SET);
		chk(BUSY, 1);
		cy(8);
		chk(INTA_REQ, 0);
		INT_ENABLE = 1;
		wt(INTA_REQ, 1);
		chk(INTA_LOCK, 1);
		INSN_BOUNDARY = 0;
		pl(ACK_CYCLE_DONE);
		chk(INTA_LOCK, 1);
		pl(ACK_CYCLE_DONE);
		chk(INTA_REQ, 0);
		pl(IRQ_ACKED);
		$display("irq done");
		pl(NMI_REQ);
		wt(NMI_TAKE, 1);
		chk(NMI_TAKE, 1);
		cy(1);
		chk(NMI_TAKE, 0);
		$display("nmi done");
		LOCKED_SEQ = 1;
		INSN_BOUNDARY = 1;
		SMI_REQ = 1;
		cy(10);
		chk(SYSMGMT_MODE, 0);
		LOCKED_SEQ = 0;
		wt(SYSMGMT_MODE, 1);
		chk(bus.sysmgmt_active_n, 0);
		chk(SMM_SEEN, 1);
		INSN_BOUNDARY = 0;
		SMI_REQ = 0;
		cy(6);
		SMI_REQ = 1;
		BASE_WE = 1;
		BASE_WDATA = 32'h00050000;
		cy(6);
		BASE_WE = 0;
		chk(SYSMGMT_MODE, 1);
		pl(RESTORE_LAST);
		chk(bus.sysmgmt_active_n, 1);
		pl(RESUME_EXEC);
		chk(SYSMGMT_MODE, 0);
		STRING_ITER = 1;
		wt(SYSMGMT_MODE, 1);
		chk(SYSMGMT_MODE, 1);
		STRING_ITER = 0;
		pl(RESTORE_LAST);
		pl(RESUME_EXEC);
		INSN_BOUNDARY = 1;
		cy(4);
		chk(SYSMGMT_MODE, 0);
		SMI_REQ = 0;
		$display("smm done");
		pl(SOFT_RESET_REQ);
		wt(CORE_RESET, 1);
		wt(CORE_RESET, 0);
		chk(SYSMGMT_BASE, 32'h00050000);
		pl(HARD_RESET_REQ);
		wt(CORE_RESET, 1);
		wt(CORE_RESET, 0);
		chk(SYSMGMT_BASE, 32'h00030000);
		chk(BUSY, 0);
		$display("pin reset done");
		CE = 0;
		pl(SOFT_RESET_REQ);
		cy(8);
		chk(CORE_RESET, 0);
		CE = 1;
		cy(8);
		chk(CORE_RESET, 0);
		$display("enable done");
		final_report;
	end
endmodule : tb_cpu_reset_interrupt_sysmgmt_inputs
